// [design/srs_defines.svh]
// Constants for the receive-status flag block
`ifndef SRS_DEFINES_SVH
`define SRS_DEFINES_SVH

// Data path widths and buffer depth
`define SRS_DATA_W      8
`define SRS_FIFO_W      9
`define SRS_FIFO_DEPTH  8
`define SRS_ERR_POS     8

// Serial status register layout
`define SRS_STAT_W      8
`define SRS_FULL_POS    6
`define SRS_OVR_POS     5

// Reset values
`define SRS_FLAG_RST    1'h0
`define SRS_BYTE_RST    8'h00
`define SRS_STAT_RST    8'h00

`endif

// [design/srs_fifo.sv]
// Receive frame FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module srs_fifo #(
    parameter int W = 9,
    parameter int D = 8
) (
    input  wire logic         sys_clk,
    input  wire logic         rstn,
    input  wire logic         ce,
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    output logic              out_valid,
    output logic [W-1:0]      out_data,
    input  wire logic         out_ready
);

    localparam int AW = (D > 1) ? $clog2(D) : 1;
    localparam logic [AW:0] FULL_CNT = (AW+1)'(D);
    localparam logic [AW-1:0] LAST_PTR = AW'(D - 1);

    logic [W-1:0]  mem [D];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0]   count_ff;
    logic [AW:0]   nxt_count;
    logic          in_ready_ff;
    logic          push;
    logic          pop;

    assign push      = in_valid && in_ready_ff;
    assign pop       = out_valid && out_ready;
    assign out_valid = (count_ff != '0);
    assign out_data  = mem[rd_ptr_ff];
    assign in_ready  = in_ready_ff;

    always_comb begin
        nxt_count = count_ff;
        if (push && !pop) begin
            nxt_count = count_ff + (AW+1)'(1);
        end else if (pop && !push) begin
            nxt_count = count_ff - (AW+1)'(1);
        end
    end

    // ==========================================================
    // Storage and pointers
    always_ff @(posedge sys_clk) begin
        if (ce && push) begin
            mem[wr_ptr_ff] <= in_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            wr_ptr_ff   <= '0;
            rd_ptr_ff   <= '0;
            count_ff    <= '0;
            in_ready_ff <= 1'h0;
        end else if (ce) begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == LAST_PTR) ? '0 : wr_ptr_ff + AW'(1);
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == LAST_PTR) ? '0 : rd_ptr_ff + AW'(1);
            end
            count_ff    <= nxt_count;
            in_ready_ff <= (nxt_count != FULL_CNT);
        end
    end

endmodule

`default_nettype wire

// [design/srs_pkg.sv]
// Types shared by the receive-status flag block
`include "srs_defines.svh"

package srs_pkg;

    typedef logic [`SRS_DATA_W-1:0] srs_byte_t;
    typedef logic [`SRS_STAT_W-1:0] srs_stat_t;
    typedef logic [`SRS_FIFO_W-1:0] srs_word_t;

    // Progress of the read-one-then-write-zero clearing sequence
    typedef enum logic [0:0] {
        SRS_IDLE  = 1'h0,
        SRS_ARMED = 1'h1
    } srs_clr_e;

endpackage

// [design/srs_rx_status.sv]
// Receive-status flags: receive-full and overrun, with buffer register
`timescale 1ns/1ps
`default_nettype none
`include "srs_defines.svh"

module srs_rx_status (
    input  wire logic              sys_clk,
    input  wire logic              rstn,
    input  wire logic              ce,
    input  wire logic              rx_valid,
    input  wire srs_pkg::srs_byte_t rx_byte,
    input  wire logic              rx_err,
    output logic                   rx_ready,
    input  wire logic              receiver_on_bit,
    input  wire logic              rx_int_en,
    input  wire logic              status_rd,
    input  wire logic              status_wr,
    input  wire srs_pkg::srs_stat_t status_wdata,
    output srs_pkg::srs_stat_t     status_rdata,
    input  wire logic              tc_read,
    output srs_pkg::srs_byte_t     receive_buffer_reg,
    output logic                   receive_full_flag,
    output logic                   overrun_flag,
    output logic                   receive_full_request
);

    // ==========================================================
    // Declarations
    srs_pkg::srs_word_t fifo_in;
    srs_pkg::srs_word_t fifo_out;
    logic               fifo_valid;
    logic               fifo_ready;
    logic               fifo_in_ready;
    logic               completion;
    logic               frame_ok;
    logic               set_full;
    logic               set_ovr;
    logic               clr_full_sw;
    logic               clr_full_tc;
    logic               clr_ovr_sw;
    logic               nxt_full;
    logic               nxt_ovr;
    logic               receive_full_ff;
    logic               overrun_ff;
    logic               request_ff;
    srs_pkg::srs_byte_t buffer_ff;
    srs_pkg::srs_stat_t rdata_ff;
    srs_pkg::srs_clr_e  full_clr_ff;
    srs_pkg::srs_clr_e  nxt_full_clr;
    srs_pkg::srs_clr_e  ovr_clr_ff;
    srs_pkg::srs_clr_e  nxt_ovr_clr;

    // ==========================================================
    // Frame buffer between shift register and buffer register
    assign fifo_in = {rx_err, rx_byte};

    // Drain stalls while the receiver is off or an overrun is pending
    assign fifo_ready = ce && receiver_on_bit && !overrun_ff;

    srs_fifo #(
        .W (`SRS_FIFO_W),
        .D (`SRS_FIFO_DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .rstn      (rstn),
        .ce        (ce),
        .in_valid  (rx_valid),
        .in_data   (fifo_in),
        .in_ready  (fifo_in_ready),
        .out_valid (fifo_valid),
        .out_data  (fifo_out),
        .out_ready (fifo_ready)
    );

    assign rx_ready = fifo_in_ready;

    // ==========================================================
    // Flag events
    assign completion = fifo_valid && fifo_ready;
    assign frame_ok   = !fifo_out[`SRS_ERR_POS];

    assign set_full = completion && frame_ok && !receive_full_ff;

    assign set_ovr = completion && receive_full_ff;

    assign clr_full_sw = status_wr && !status_wdata[`SRS_FULL_POS]
                         && (full_clr_ff == srs_pkg::SRS_ARMED);

    assign clr_full_tc = tc_read && request_ff;

    assign clr_ovr_sw = status_wr && !status_wdata[`SRS_OVR_POS]
                        && (ovr_clr_ff == srs_pkg::SRS_ARMED);

    always_comb begin
        nxt_full = receive_full_ff;
        if (receiver_on_bit) begin
            if (set_full) begin
                nxt_full = 1'h1;
            end else if (clr_full_sw || clr_full_tc) begin
                nxt_full = 1'h0;
            end
        end
    end

    always_comb begin
        nxt_ovr = overrun_ff;
        if (set_ovr) begin
            nxt_ovr = 1'h1;
        end else if (clr_ovr_sw) begin
            nxt_ovr = 1'h0;
        end
    end

    // ==========================================================
    // Clearing sequence trackers
    always_comb begin
        nxt_full_clr = full_clr_ff;
        case (full_clr_ff)
            srs_pkg::SRS_IDLE: begin
                if (status_rd && receive_full_ff) begin
                    nxt_full_clr = srs_pkg::SRS_ARMED;
                end
            end
            srs_pkg::SRS_ARMED: begin
                if (status_rd && receive_full_ff) begin
                    nxt_full_clr = srs_pkg::SRS_ARMED;
                end else if (status_wr) begin
                    nxt_full_clr = srs_pkg::SRS_IDLE;
                end
            end
            default: begin
                nxt_full_clr = srs_pkg::SRS_IDLE;
            end
        endcase
    end

    always_comb begin
        nxt_ovr_clr = ovr_clr_ff;
        case (ovr_clr_ff)
            srs_pkg::SRS_IDLE: begin
                if (status_rd && overrun_ff) begin
                    nxt_ovr_clr = srs_pkg::SRS_ARMED;
                end
            end
            srs_pkg::SRS_ARMED: begin
                if (status_rd && overrun_ff) begin
                    nxt_ovr_clr = srs_pkg::SRS_ARMED;
                end else if (status_wr) begin
                    nxt_ovr_clr = srs_pkg::SRS_IDLE;
                end
            end
            default: begin
                nxt_ovr_clr = srs_pkg::SRS_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            full_clr_ff <= srs_pkg::SRS_IDLE;
            ovr_clr_ff  <= srs_pkg::SRS_IDLE;
        end else if (ce) begin
            full_clr_ff <= nxt_full_clr;
            ovr_clr_ff  <= nxt_ovr_clr;
        end
    end

    // ==========================================================
    // Flags and request
    // receive-full resets to zero
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            receive_full_ff <= `SRS_FLAG_RST;
        end else if (ce) begin
            receive_full_ff <= nxt_full;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            overrun_ff <= `SRS_FLAG_RST;
        end else if (ce) begin
            overrun_ff <= nxt_ovr;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            request_ff <= `SRS_FLAG_RST;
        end else if (ce) begin
            request_ff <= nxt_full && rx_int_en;
        end
    end

    // ==========================================================
    // Buffer register and status read-back
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            buffer_ff <= `SRS_BYTE_RST;
        end else if (ce && receiver_on_bit && set_full) begin
            buffer_ff <= fifo_out[`SRS_DATA_W-1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            rdata_ff <= `SRS_STAT_RST;
        end else if (ce && status_rd) begin
            rdata_ff                <= `SRS_STAT_RST;
            rdata_ff[`SRS_FULL_POS] <= receive_full_ff;
            rdata_ff[`SRS_OVR_POS]  <= overrun_ff;
        end
    end

    assign receive_buffer_reg   = buffer_ff;
    assign receive_full_flag    = receive_full_ff;
    assign overrun_flag         = overrun_ff;
    assign receive_full_request = request_ff;
    assign status_rdata         = rdata_ff;

    // ==========================================================
    // Checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    sequence s_full_read_one;
        ce && status_rd && receive_full_flag;
    endsequence

    sequence s_full_write_zero;
        ce && status_wr && !status_rdata[`SRS_STAT_W-1] && !status_wdata[`SRS_FULL_POS]
        && receiver_on_bit && !set_full && !status_rd;
    endsequence

    sequence s_ovr_read_one;
        ce && status_rd && overrun_flag;
    endsequence

    sequence s_ovr_write_zero;
        ce && status_wr && !status_wdata[`SRS_OVR_POS] && !status_rd && !set_ovr;
    endsequence

    a_full_set_load: assert property (
        (ce && receiver_on_bit && fifo_valid && fifo_ready && frame_ok && !receive_full_flag)
        |=> (receive_full_flag && receive_buffer_reg == $past(fifo_out[`SRS_DATA_W-1:0])))
        else $error("receive-full not set with byte on good reception");

    a_full_sw_clear: assert property (
        s_full_read_one ##1 s_full_write_zero |=> !receive_full_flag)
        else $error("receive-full not cleared by read-one write-zero");

    a_full_no_stray: assert property (
        (receive_full_flag && ce && !status_wr && !tc_read) |=> receive_full_flag)
        else $error("receive-full cleared without a cause");

    a_full_tc_clear: assert property (
        (ce && receiver_on_bit && tc_read && receive_full_request && !set_full)
        |=> !receive_full_flag)
        else $error("receive-full not cleared by transfer controller read");

    a_full_hold_off: assert property (
        (ce && !receiver_on_bit) |=> $stable(receive_full_flag))
        else $error("receive-full changed while receiver off");

    a_ovr_set: assert property (
        (ce && fifo_valid && fifo_ready && receive_full_flag) |=> overrun_flag[*2])
        else $error("overrun not set on reception over full buffer");

    a_status_bits: assert property (
        (ce && status_rd) |=> (status_rdata[`SRS_FULL_POS] == $past(receive_full_flag)
        && status_rdata[`SRS_OVR_POS] == $past(overrun_flag)))
        else $error("status flag bits misplaced");

    a_ovr_sw_clear: assert property (
        s_ovr_read_one ##1 s_ovr_write_zero |=> !overrun_flag)
        else $error("overrun not cleared by read-one write-zero");

    a_request_level: assert property (
        (ce && rx_int_en && receive_full_flag) |=> ##[0:1] (receive_full_request
        || !receive_full_flag || !$past(rx_int_en)))
        else $error("receive-full request missing while flag set");

    a_freeze_ce: assert property (
        !ce |=> ($stable(receive_full_flag) && $stable(overrun_flag)
        && $stable(receive_buffer_reg)))
        else $error("state changed with clock enable low");

endmodule

`default_nettype wire

// [verification/serial_receive_status_flags_bench.sv]
// Self-checking bench for the receive-status flag block
`timescale 1ns/1ps
`default_nettype none

module serial_receive_status_flags_bench;
    logic               sys_clk, rstn, ce, rx_valid, rx_err, rx_ready;
    logic               receiver_on_bit, rx_int_en, status_rd, status_wr, tc_read;
    logic               receive_full_flag, overrun_flag, receive_full_request;
    srs_pkg::srs_byte_t rx_byte, receive_buffer_reg;
    srs_pkg::srs_stat_t status_wdata, status_rdata;
    int                 miscompares = 0;
    int                 n_tests = 0;

    srs_rx_status i_dut (
        .sys_clk(sys_clk), .rstn(rstn), .ce(ce), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .rx_err(rx_err), .rx_ready(rx_ready), .receiver_on_bit(receiver_on_bit),
        .rx_int_en(rx_int_en), .status_rd(status_rd), .status_wr(status_wr),
        .status_wdata(status_wdata), .status_rdata(status_rdata), .tc_read(tc_read),
        .receive_buffer_reg(receive_buffer_reg), .receive_full_flag(receive_full_flag),
        .overrun_flag(overrun_flag), .receive_full_request(receive_full_request)
    );

    srs_rx_source i_src (
        .sys_clk(sys_clk), .rstn(rstn), .ce(ce), .rx_ready(rx_ready),
        .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_err(rx_err)
    );

    initial begin
        sys_clk = 1'h0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic rd();
        status_rd = 1'h1;
        cyc(1);
        status_rd = 1'h0;
    endtask

    task automatic wr(input srs_pkg::srs_stat_t d);
        status_wr = 1'h1;
        status_wdata = d;
        cyc(1);
        status_wr = 1'h0;
        cyc(1);
    endtask

    task automatic tc();
        tc_read = 1'h1;
        cyc(1);
        tc_read = 1'h0;
        cyc(1);
    endtask

    task automatic t_reset();
        chk("full", 8'h00, receive_full_flag);
        chk("overrun", 8'h00, overrun_flag);
        chk("status", 8'h00, status_rdata);
        chk("buffer", 8'h00, receive_buffer_reg);
        chk("request", 8'h00, receive_full_request);
        $display("t_reset done");
    endtask

    task automatic t_receive();
        i_src.send(1'h0, 8'hA5);
        cyc(4);
        chk("full", 8'h01, receive_full_flag);
        chk("buffer", 8'hA5, receive_buffer_reg);
        chk("request", 8'h01, receive_full_request);
        wr(8'h00);
        chk("full unread", 8'h01, receive_full_flag);
        rd();
        chk("status", 8'h40, status_rdata);
        wr(8'h00);
        chk("full clear", 8'h00, receive_full_flag);
        chk("request off", 8'h00, receive_full_request);
        $display("t_receive done");
    endtask

    task automatic t_mask();
        rx_int_en = 1'h0;
        i_src.send(1'h0, 8'h3C);
        cyc(4);
        chk("full", 8'h01, receive_full_flag);
        chk("masked", 8'h00, receive_full_request);
        tc();
        chk("tc masked", 8'h01, receive_full_flag);
        rx_int_en = 1'h1;
        cyc(2);
        chk("request", 8'h01, receive_full_request);
        tc();
        chk("tc clear", 8'h00, receive_full_flag);
        $display("t_mask done");
    endtask

    task automatic t_overrun();
        i_src.send(1'h0, 8'h11);
        i_src.send(1'h0, 8'h22);
        cyc(5);
        chk("overrun", 8'h01, overrun_flag);
        chk("buffer", 8'h11, receive_buffer_reg);
        rd();
        chk("status", 8'h60, status_rdata);
        wr(8'h40);
        chk("overrun clr", 8'h00, overrun_flag);
        chk("full kept", 8'h01, receive_full_flag);
        tc();
        chk("tc clear", 8'h00, receive_full_flag);
        $display("t_overrun done");
    endtask

    task automatic t_error();
        i_src.send(1'h1, 8'h77);
        cyc(4);
        chk("full", 8'h00, receive_full_flag);
        chk("buffer", 8'h11, receive_buffer_reg);
        $display("t_error done");
    endtask

    task automatic t_freeze();
        ce = 1'h0;
        i_src.send(1'h0, 8'h5A);
        cyc(4);
        chk("frozen full", 8'h00, receive_full_flag);
        chk("frozen ready", 8'h01, rx_ready);
        ce = 1'h1;
        cyc(4);
        chk("full", 8'h01, receive_full_flag);
        chk("buffer", 8'h5A, receive_buffer_reg);
        ce = 1'h0;
        tc();
        chk("frozen tc", 8'h01, receive_full_flag);
        ce = 1'h1;
        tc();
        chk("tc clear", 8'h00, receive_full_flag);
        $display("t_freeze done");
    endtask

    task automatic t_off_clear();
        i_src.send(1'h0, 8'h44);
        cyc(4);
        receiver_on_bit = 1'h0;
        rd();
        wr(8'h00);
        chk("full off", 8'h01, receive_full_flag);
        tc();
        chk("full off tc", 8'h01, receive_full_flag);
        receiver_on_bit = 1'h1;
        rd();
        wr(8'h00);
        chk("full clear", 8'h00, receive_full_flag);
        $display("t_off_clear done");
    endtask

    task automatic t_fill();
        receiver_on_bit = 1'h0;
        for (int i = 0; i < 9; i++) begin
            i_src.send(1'h0, 8'h80 + 8'(i));
        end
        cyc(14);
        chk("ready full", 8'h00, rx_ready);
        chk("full off", 8'h00, receive_full_flag);
        receiver_on_bit = 1'h1;
        // Each of the first four rounds buffers one word and the next one overruns; the fifth buffers the ninth word with no overrun
        for (int k = 0; k < 5; k++) begin
            cyc(3);
            chk("buffer", 8'h80 + 8'(2 * k), receive_buffer_reg);
            chk("overrun", (k < 4) ? 8'h01 : 8'h00, overrun_flag);
            rd();
            wr(8'h00);
        end
        chk("full end", 8'h00, receive_full_flag);
        chk("ready end", 8'h01, rx_ready);
        $display("t_fill done");
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        #(25 * 3000);
        miscompares++;
        test_done();
    end

    initial begin
        rstn = 1'h0;
        ce = 1'h1;
        receiver_on_bit = 1'h1;
        rx_int_en = 1'h1;
        status_rd = 1'h0;
        status_wr = 1'h0;
        status_wdata = 8'h00;
        tc_read = 1'h0;
        repeat (6) @(posedge sys_clk);
        @(negedge sys_clk);
        t_reset();
        rstn = 1'h1;
        cyc(2);
        t_receive();
        t_mask();
        t_overrun();
        t_error();
        t_freeze();
        t_off_clear();
        t_fill();
        test_done();
    end
endmodule

`default_nettype wire

// [verification/srs_rx_source.sv]
// Model of the receive shift register that offers completed frames
`timescale 1ns/1ps
`default_nettype none

module srs_rx_source (
    input  wire logic          sys_clk,
    input  wire logic          rstn,
    input  wire logic          ce,
    input  wire logic          rx_ready,
    output logic               rx_valid,
    output srs_pkg::srs_byte_t rx_byte,
    output logic               rx_err
);
    srs_pkg::srs_word_t q[$];
    logic               taken;

    initial begin
        rx_valid = 1'h0;
        rx_byte = 8'h00;
        rx_err = 1'h0;
        taken = 1'h0;
    end

    task automatic send(input logic err, input srs_pkg::srs_byte_t b);
        q.push_back({err, b});
    endtask

    always @(posedge sys_clk) begin
        taken <= rx_valid && rx_ready && ce && rstn;
    end

    // Hold the head frame until taken; idle lines toggle so stale data never looks valid
    always @(negedge sys_clk) begin
        if (taken) begin
            void'(q.pop_front());
        end
        if (q.size() > 0) begin
            rx_valid = 1'h1;
            {rx_err, rx_byte} = q[0];
        end else begin
            rx_valid = 1'h0;
            rx_byte = ~rx_byte;
            rx_err = ~rx_err;
        end
    end
endmodule

`default_nettype wire
